// file: common/vis_pkg.sv
/*
  Constants and types for the video input select configuration block:
  register offsets, page codes, reset values, format codes, routing types.
  Assumes a single 20 MHz clock domain and a two-wire serial host.
*/
package vis_pkg;

  // ---------------------------------------------------------------
  // Serial port
  // ---------------------------------------------------------------
  localparam logic [5:0] DEV_ADDR_HI  = 6'h10;
  localparam int         CLK_HZ       = 20_000_000;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_FORMAT   = 8'h00;
  localparam logic [7:0] OFS_PAGE     = 8'h0E;
  localparam logic [7:0] OFS_BOOST    = 8'h80;
  localparam logic [7:0] OFS_DEINT    = 8'hFE;
  localparam logic [7:0] OFS_LAST     = 8'hFF;

  // ---------------------------------------------------------------
  // Field positions and page codes
  // ---------------------------------------------------------------
  localparam int         FORMAT_MSB   = 4;
  localparam int         PAGE_LSB     = 5;
  localparam int         PAGE_MSB     = 6;
  localparam int         BOOST_BIT    = 7;
  localparam int         DEINT_BIT    = 0;
  localparam logic [1:0] PAGE_USER    = 2'h0;
  localparam logic [1:0] PAGE_INTR    = 2'h1;
  localparam logic [1:0] PAGE_USER2   = 2'h2;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_FORMAT   = 8'h00;
  localparam logic [7:0] RST_PAGE     = 8'h00;
  localparam logic [7:0] RST_BOOST    = 8'h00;
  localparam logic [7:0] RST_DEINT    = 8'h00;

  // ---------------------------------------------------------------
  // Input format codes
  // ---------------------------------------------------------------
  localparam logic [4:0] FMT_CVBS1    = 5'h00;
  localparam logic [4:0] FMT_CVBS2    = 5'h01;
  localparam logic [4:0] FMT_CVBS3    = 5'h02;
  localparam logic [4:0] FMT_CVBS4    = 5'h03;
  localparam logic [4:0] FMT_CVBS5    = 5'h06;
  localparam logic [4:0] FMT_CVBS6    = 5'h07;
  localparam logic [4:0] FMT_YC12     = 5'h08;
  localparam logic [4:0] FMT_YC34     = 5'h09;
  localparam logic [4:0] FMT_YC56     = 5'h0B;
  localparam logic [4:0] FMT_COMP     = 5'h0C;
  localparam logic [4:0] FMT_DIFF12   = 5'h0E;
  localparam logic [4:0] FMT_DIFF34   = 5'h0F;
  localparam logic [4:0] FMT_DIFF56   = 5'h11;

  // ---------------------------------------------------------------
  // Routing types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_OFF  = 3'h0,
    MODE_CVBS = 3'h1,
    MODE_YC   = 3'h2,
    MODE_COMP = 3'h3,
    MODE_DIFF = 3'h4
  } vis_mode_e;

  // Channel fields hold numbers 1..6, 0 when unused
  typedef struct packed {
    vis_mode_e  mode;
    logic [2:0] chan_a;
    logic [2:0] chan_b;
    logic [2:0] chan_c;
    logic [5:0] power_on;
  } vis_route_s;

endpackage : vis_pkg

// file: core/vis_config.sv
/*
  Configuration logic of a video decoder: two-wire serial slave, paged
  register bank, input routing decode and channel power control.
  Assumes scl_in/sda_in are already synchronous to clk and that the
  board combines sda_out/sda_oe_n into an open-drain wire.
*/
// Summary of operation
// - Input format select is five bits, bits 4:0 of register 0x00, page one.
// - Codes 00000-00011 give composite on channels 1-4; 00110, 00111 on 5, 6.
// - Codes 01000, 01001, 01011 pick luma/chroma on pairs 1-2, 3-4, 5-6.
// - Code 01100 picks component: luma ch1, blue diff ch2, red diff ch3.
// - Codes 01110, 01111, 10001: differential composite, pairs 1-2, 3-4, 5-6.
// - Channels unused by the chosen routing are powered down.
// - Contrast boost is off after reset until the host enables it.
// - Writing 0x40 to register register_page_select switches to the second page.
// - Writing 0x00 to register register_page_select returns to the first page.
// - Writing contrast_boost_control to register contrast_boost_control on page two turns boost on.
// - Writing 0x00 to register contrast_boost_control on page two turns boost off.
// - Deinterlace converter is off after reset until the host programs it.
// - Page select is bits 6:5 of register_page_select; 00 first page, 10 second.
// - Address select pin sets bit 1 of the write address: 0x40 or 0x42.
`timescale 1ns/100ps

module vis_config (
  input  wire logic             clk,                  // 20 MHz clock
  input  wire logic             sys_rst,              // Sync reset, high
  input  wire logic             ce,                   // Clock enable
  input  wire logic             address_select_pin,   // Address bit 1
  input  wire logic             scl_in,               // Serial clock
  input  wire logic             sda_in,               // Serial data in
  output logic                  sda_out,              // Serial data out
  output logic                  sda_oe_n,             // Low drives sda
  output vis_pkg::vis_route_s   route,                // Channel routing
  output logic                  adaptive_contrast_boost, // Boost on
  output logic                  deinterlace_converter,   // I-to-P on
  output logic [1:0]            page_sel              // Current page
);

  // ---------------------------------------------------------------
  // Types and helpers
  // ---------------------------------------------------------------
  typedef enum logic [8:0] {
    ST_IDLE    = 9'h001,
    ST_ADDR    = 9'h002,
    ST_ADDR_AK = 9'h004,
    ST_SUB     = 9'h008,
    ST_SUB_AK  = 9'h010,
    ST_WDATA   = 9'h020,
    ST_WDAT_AK = 9'h040,
    ST_RDATA   = 9'h080,
    ST_RDAT_AK = 9'h100
  } vis_state_e;

  function automatic vis_pkg::vis_route_s route_of(input logic [4:0] code);
    vis_pkg::vis_route_s r;
    r = '{mode: vis_pkg::MODE_OFF, chan_a: 3'h0, chan_b: 3'h0,
          chan_c: 3'h0, power_on: 6'h00};
    case (code)
      vis_pkg::FMT_CVBS1, vis_pkg::FMT_CVBS2,
      vis_pkg::FMT_CVBS3, vis_pkg::FMT_CVBS4: begin
        r.mode   = vis_pkg::MODE_CVBS;
        r.chan_a = code[2:0] + 3'h1;
      end
      vis_pkg::FMT_CVBS5, vis_pkg::FMT_CVBS6: begin
        r.mode   = vis_pkg::MODE_CVBS;
        r.chan_a = code[2:0] - 3'h1;
      end
      vis_pkg::FMT_YC12, vis_pkg::FMT_YC34, vis_pkg::FMT_YC56: begin
        r.mode   = vis_pkg::MODE_YC;
        // Low code bits 00, 01, 11 give luma channels 1, 3, 5
        r.chan_a = {code[1], code[0] & ~code[1], 1'b1};
        r.chan_b = {code[1], code[0] & ~code[1], 1'b1} + 3'h1;
      end
      vis_pkg::FMT_COMP: begin
        r.mode   = vis_pkg::MODE_COMP;
        r.chan_a = 3'h1;
        r.chan_b = 3'h2;
        r.chan_c = 3'h3;
      end
      vis_pkg::FMT_DIFF12: begin
        r.mode   = vis_pkg::MODE_DIFF;
        r.chan_a = 3'h1;
        r.chan_b = 3'h2;
      end
      vis_pkg::FMT_DIFF34: begin
        r.mode   = vis_pkg::MODE_DIFF;
        r.chan_a = 3'h3;
        r.chan_b = 3'h4;
      end
      vis_pkg::FMT_DIFF56: begin
        r.mode   = vis_pkg::MODE_DIFF;
        r.chan_a = 3'h5;
        r.chan_b = 3'h6;
      end
      default: begin
        r.mode   = vis_pkg::MODE_OFF;
      end
    endcase
    for (int i = 0; i < 6; i++) begin
      r.power_on[i] = (r.chan_a == 3'(i + 1)) || (r.chan_b == 3'(i + 1))
                   || (r.chan_c == 3'(i + 1));
    end
    return r;
  endfunction : route_of

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  vis_state_e          st_reg,    st_next;
  logic [3:0]          cnt_reg,   cnt_next;
  logic [7:0]          sh_reg,    sh_next;
  logic [7:0]          tx_reg,    tx_next;
  logic [7:0]          ptr_reg,   ptr_next;
  logic                rw_reg,    rw_next;
  logic                ack_reg,   ack_next;
  logic                oe_n_reg,  oe_n_next;
  logic                scl_q_reg, sda_q_reg;
  logic [7:0]          fmt_reg,   fmt_next;
  logic [7:0]          page_reg,  page_next;
  logic [7:0]          boost_reg, boost_next;
  logic [7:0]          deint_reg, deint_next;
  vis_pkg::vis_route_s route_reg, route_next;
  logic                wr_en;
  logic                scl_rise, scl_fall, start_cond, stop_cond;
  logic                addr_hit;
  logic [1:0]          page;

  assign page       = page_reg[vis_pkg::PAGE_MSB:vis_pkg::PAGE_LSB];
  assign scl_rise   = scl_in & ~scl_q_reg;
  assign scl_fall   = ~scl_in & scl_q_reg;
  assign start_cond = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
  assign stop_cond  = scl_in & scl_q_reg & ~sda_q_reg & sda_in;
  assign addr_hit   = sh_reg[7:1] == {vis_pkg::DEV_ADDR_HI,
                                      address_select_pin};

  // Subaddress map of each page
  function automatic logic sub_ok(input logic [7:0] a, input logic [1:0] p);
    logic ok;
    ok = (a == vis_pkg::OFS_PAGE);
    if (p == vis_pkg::PAGE_USER) begin
      ok = ok || (a == vis_pkg::OFS_FORMAT) || (a == vis_pkg::OFS_DEINT);
    end else if (p == vis_pkg::PAGE_USER2) begin
      ok = ok || (a == vis_pkg::OFS_BOOST);
    end
    return ok;
  endfunction : sub_ok

  function automatic logic [7:0] rd_of(input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (sub_ok(a, page)) begin
      case (a)
        vis_pkg::OFS_FORMAT: d = fmt_reg;
        vis_pkg::OFS_PAGE:   d = page_reg;
        vis_pkg::OFS_BOOST:  d = boost_reg;
        vis_pkg::OFS_DEINT:  d = deint_reg;
        default:             d = 8'h00;
      endcase
    end
    return d;
  endfunction : rd_of

  function automatic logic [7:0] inc_of(input logic [7:0] a);
    return (a == vis_pkg::OFS_LAST) ? a : a + 8'h01;
  endfunction : inc_of

  // ---------------------------------------------------------------
  // Serial slave
  // ---------------------------------------------------------------
  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    sh_next  = sh_reg;
    tx_next  = tx_reg;
    ptr_next = ptr_reg;
    rw_next  = rw_reg;
    ack_next = ack_reg;
    wr_en    = 1'b0;
    if (scl_rise) begin
      case (st_reg)
        ST_ADDR, ST_SUB, ST_WDATA: begin
          sh_next  = {sh_reg[6:0], sda_in};
          cnt_next = cnt_reg + 4'h1;
        end
        ST_RDATA:   cnt_next = cnt_reg + 4'h1;
        ST_RDAT_AK: ack_next = ~sda_in;
        default:    ;
      endcase
    end
    if (scl_fall) begin
      case (st_reg)
        ST_ADDR: begin
          if (cnt_reg == 4'h8) begin
            st_next = addr_hit ? ST_ADDR_AK : ST_IDLE;
            rw_next = sh_reg[0];
          end
        end
        ST_ADDR_AK: begin
          cnt_next = 4'h0;
          if (rw_reg) begin
            st_next = ST_RDATA;
            tx_next = rd_of(ptr_reg);
          end else begin
            st_next = ST_SUB;
          end
        end
        ST_SUB: begin
          if (cnt_reg == 4'h8) begin
            st_next  = sub_ok(sh_reg, page) ? ST_SUB_AK : ST_IDLE;
            ptr_next = sh_reg;
          end
        end
        ST_SUB_AK, ST_WDAT_AK: begin
          st_next  = ST_WDATA;
          cnt_next = 4'h0;
        end
        ST_WDATA: begin
          if (cnt_reg == 4'h8) begin
            if (sub_ok(ptr_reg, page)) begin
              wr_en   = 1'b1;
              st_next = ST_WDAT_AK;
            end else begin
              st_next = ST_IDLE;
            end
          end
        end
        ST_RDATA: begin
          if (cnt_reg == 4'h8) begin
            st_next = ST_RDAT_AK;
          end else begin
            tx_next = {tx_reg[6:0], 1'b0};
          end
        end
        ST_RDAT_AK: begin
          cnt_next = 4'h0;
          if (ack_reg) begin
            st_next  = ST_RDATA;
            ptr_next = inc_of(ptr_reg);
            tx_next  = rd_of(inc_of(ptr_reg));
          end else begin
            st_next = ST_IDLE;
          end
        end
        default: ;
      endcase
    end
    if (st_reg == ST_WDAT_AK && scl_fall) begin
      ptr_next = inc_of(ptr_reg);
    end
    if (start_cond) begin
      st_next  = ST_ADDR;
      cnt_next = 4'h0;
    end else if (stop_cond) begin
      st_next = ST_IDLE;
    end
    oe_n_next = ~((st_next == ST_ADDR_AK) || (st_next == ST_SUB_AK)
               || (st_next == ST_WDAT_AK)
               || (st_next == ST_RDATA && !tx_next[7]));
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg    <= ST_IDLE;
      cnt_reg   <= 4'h0;
      sh_reg    <= 8'h00;
      tx_reg    <= 8'h00;
      ptr_reg   <= 8'h00;
      rw_reg    <= 1'b0;
      ack_reg   <= 1'b0;
      oe_n_reg  <= 1'b1;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else if (ce) begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      sh_reg    <= sh_next;
      tx_reg    <= tx_next;
      ptr_reg   <= ptr_next;
      rw_reg    <= rw_next;
      ack_reg   <= ack_next;
      oe_n_reg  <= oe_n_next;
      scl_q_reg <= scl_in;
      sda_q_reg <= sda_in;
    end
  end

  // ---------------------------------------------------------------
  // Register bank and routing
  // ---------------------------------------------------------------
  always_comb begin
    fmt_next   = fmt_reg;
    page_next  = page_reg;
    boost_next = boost_reg;
    deint_next = deint_reg;
    if (wr_en) begin
      case (ptr_reg)
        vis_pkg::OFS_PAGE:   page_next  = sh_reg;
        vis_pkg::OFS_FORMAT: fmt_next   = sh_reg;
        vis_pkg::OFS_BOOST:  boost_next = sh_reg;
        vis_pkg::OFS_DEINT:  deint_next = sh_reg;
        default:             ;
      endcase
    end
    route_next = route_of(fmt_next[vis_pkg::FORMAT_MSB:0]);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fmt_reg   <= vis_pkg::RST_FORMAT;
      page_reg  <= vis_pkg::RST_PAGE;
      boost_reg <= vis_pkg::RST_BOOST;
      deint_reg <= vis_pkg::RST_DEINT;
      route_reg <= route_of(vis_pkg::RST_FORMAT[vis_pkg::FORMAT_MSB:0]);
    end else if (ce) begin
      fmt_reg   <= fmt_next;
      page_reg  <= page_next;
      boost_reg <= boost_next;
      deint_reg <= deint_next;
      route_reg <= route_next;
    end
  end

  assign sda_out                 = 1'b0;
  assign sda_oe_n                = oe_n_reg;
  assign route                   = route_reg;
  assign adaptive_contrast_boost = boost_reg[vis_pkg::BOOST_BIT];
  assign deinterlace_converter   = deint_reg[vis_pkg::DEINT_BIT];
  assign page_sel                = page;

endmodule : vis_config

// file: verif/vis_host_model.sv
/*
  Two-wire serial host model for the video input select block.
  Assumes the bench resolves the open-drain data wire into sda_line.
*/
`timescale 1ns/100ps

module vis_host_model (
  input  wire logic clk,      // Bench clock
  input  wire logic sda_line, // Resolved data wire
  output logic      scl,      // Serial clock
  output logic      sda_drv   // Host data, 1 releases
);
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // ---------------------------------------------------------------
  // Bus phases, four clocks each; scl stands high between frames
  // ---------------------------------------------------------------
  task automatic half();
    repeat (4) @(negedge clk);
  endtask : half

  task automatic start_c();
    sda_drv = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b0;
    half();
    scl = 1'b0;
    half();
  endtask : start_c

  task automatic stop_c();
    sda_drv = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b1;
    half();
  endtask : stop_c

  // Eight bits plus acknowledge slot, MSB first; s holds the wire samples
  task automatic xfer(input logic [8:0] v, output logic [8:0] s);
    for (int i = 8; i >= 0; i--) begin
      sda_drv = v[i];
      half();
      scl = 1'b1;
      half();
      s[i] = sda_line;
      scl = 1'b0;
      half();
    end
  endtask : xfer

  // ---------------------------------------------------------------
  // Register access
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] dev, input logic [7:0] sub,
                    input logic [7:0] dat, output logic [2:0] ak);
    logic [8:0] s;
    start_c();
    xfer({dev, 1'b1}, s);
    ak[2] = ~s[0];
    xfer({sub, 1'b1}, s);
    ak[1] = ~s[0];
    xfer({dat, 1'b1}, s);
    ak[0] = ~s[0];
    stop_c();
  endtask : wr

  task automatic rd(input logic [7:0] dev, input logic [7:0] sub,
                    output logic [7:0] dat);
    logic [8:0] s;
    start_c();
    xfer({dev, 1'b1}, s);
    xfer({sub, 1'b1}, s);
    start_c();
    xfer({dev | 8'h01, 1'b1}, s);
    xfer(9'h1FF, s);
    dat = s[8:1];
    stop_c();
  endtask : rd
endmodule : vis_host_model

// file: verif/vis_config_chk.sv
/*
  Port checker for the video input select configuration block.
  Assumes the single clk domain with synchronous sys_rst.
*/
`timescale 1ns/100ps

module vis_config_chk (
  input wire logic                clk,                     // Clock
  input wire logic                sys_rst,                 // Reset
  input wire logic                ce,                      // Enable
  input wire logic                address_select_pin,      // Addr bit
  input wire logic                scl_in,                  // Serial clk
  input wire logic                sda_in,                  // Data wire
  input wire logic                sda_out,                 // Data out
  input wire logic                sda_oe_n,                // Low drives
  input wire vis_pkg::vis_route_s route,                   // Routing
  input wire logic                adaptive_contrast_boost, // Boost
  input wire logic                deinterlace_converter,   // Deint
  input wire logic [1:0]          page_sel                 // Page
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  function automatic logic [5:0] oh(input logic [2:0] ch);
    return (ch == 3'h0) ? 6'h00 : (6'h01 << (ch - 3'h1));
  endfunction : oh

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_reset_vals: assert property ($fell(sys_rst) |->
    !adaptive_contrast_boost && !deinterlace_converter && page_sel == 2'h0
    && sda_oe_n) else $error("outputs not at reset values");
  a_cvbs_route: assert property (route.mode == vis_pkg::MODE_CVBS |->
    route.chan_a inside {[3'h1:3'h6]} && {route.chan_b, route.chan_c} == 6'h00
    && route.power_on == oh(route.chan_a)) else $error("bad composite route");
  a_yc_route: assert property (route.mode == vis_pkg::MODE_YC |->
    route.chan_a inside {3'h1, 3'h3, 3'h5}
    && route.chan_b == route.chan_a + 3'h1 && route.chan_c == 3'h0
    && route.power_on == (oh(route.chan_a) | oh(route.chan_b)))
    else $error("bad luma chroma route");
  a_comp_route: assert property (route.mode == vis_pkg::MODE_COMP |->
    {route.chan_a, route.chan_b, route.chan_c} == 9'h053
    && route.power_on == 6'h07) else $error("bad component route");
  a_diff_route: assert property (route.mode == vis_pkg::MODE_DIFF |->
    route.chan_a inside {3'h1, 3'h3, 3'h5}
    && route.chan_b == route.chan_a + 3'h1 && route.chan_c == 3'h0
    && route.power_on == (oh(route.chan_a) | oh(route.chan_b)))
    else $error("bad differential route");
  a_off_route: assert property (route.mode == vis_pkg::MODE_OFF |->
    route.power_on == 6'h00) else $error("channels powered while off");
  a_boost_page: assert property ($changed(adaptive_contrast_boost)
    && !$past(sys_rst) |-> $past(page_sel) == vis_pkg::PAGE_USER2)
    else $error("boost changed outside second page");
  a_deint_page: assert property ($changed(deinterlace_converter)
    && !$past(sys_rst) |-> $past(page_sel) == vis_pkg::PAGE_USER)
    else $error("deinterlace changed outside first page");
  a_ack_scl_low: assert property ($fell(sda_oe_n) |-> !scl_in
    && sda_out == 1'b0) else $error("data driven while clock high");

  c_boost_on: cover property ($rose(adaptive_contrast_boost));
  c_comp:     cover property (route.mode == vis_pkg::MODE_COMP);
  c_page2:    cover property (page_sel == vis_pkg::PAGE_USER2);
  c_ack:      cover property ($fell(sda_oe_n));
endmodule : vis_config_chk

bind vis_config vis_config_chk u_chk (.clk(clk), .sys_rst(sys_rst),
  .ce(ce), .address_select_pin(address_select_pin), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .route(route),
  .adaptive_contrast_boost(adaptive_contrast_boost),
  .deinterlace_converter(deinterlace_converter), .page_sel(page_sel));

// file: verif/vis_config_tb.sv
/*
  Testbench for the video input select configuration block.
  Assumes vis_host_model plays the serial host on an open-drain wire.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end

module vis_config_tb;
  logic                clk, sys_rst, ce, address_select_pin, host_sda;
  logic                scl_in, sda_in, sda_out, sda_oe_n;
  logic                adaptive_contrast_boost, deinterlace_converter;
  logic [1:0]          page_sel;
  vis_pkg::vis_route_s route;
  logic [2:0]          ak;
  logic [7:0]          rdat;
  logic [8:0]          chans;
  int                  err_count = 0;
  int                  n_tests = 0;
  // Code, mode, chan a, b, c; reserved codes are never sent
  localparam logic [16:0] TBL [13] = '{
    {5'h00,3'h1,9'o100}, {5'h01,3'h1,9'o200}, {5'h02,3'h1,9'o300},
    {5'h03,3'h1,9'o400}, {5'h06,3'h1,9'o500}, {5'h07,3'h1,9'o600},
    {5'h08,3'h2,9'o120}, {5'h09,3'h2,9'o340}, {5'h0B,3'h2,9'o560},
    {5'h0C,3'h3,9'o123}, {5'h0E,3'h4,9'o120}, {5'h0F,3'h4,9'o340},
    {5'h11,3'h4,9'o560}};
  localparam logic [7:0] BV [3] = '{8'h80, 8'h00, 8'h80};

  assign sda_in = host_sda & (sda_oe_n | sda_out);
  assign chans  = {route.chan_a, route.chan_b, route.chan_c};

  vis_host_model u_host (.clk(clk), .sda_line(sda_in), .scl(scl_in),
                         .sda_drv(host_sda));

  vis_config u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .address_select_pin(address_select_pin), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .route(route),
    .adaptive_contrast_boost(adaptive_contrast_boost),
    .deinterlace_converter(deinterlace_converter), .page_sel(page_sel));

  function automatic logic [5:0] oh(input logic [2:0] ch);
    return (ch == 3'h0) ? 6'h00 : (6'h01 << (ch - 3'h1));
  endfunction : oh

  function automatic logic [5:0] pw(input logic [8:0] c);
    return oh(c[8:6]) | oh(c[5:3]) | oh(c[2:0]);
  endfunction : pw

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    ce = 1'b1;
    address_select_pin = 1'b0;
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(adaptive_contrast_boost, 1'b0)
    `CHK(deinterlace_converter, 1'b0)
    `CHK(route.power_on, 6'h01)
    u_host.rd(8'h40, 8'h0E, rdat);
    `CHK(rdat, 8'h00)
    $display("Test reset done");
    for (int i = 0; i < 13; i++) begin
      u_host.wr(8'h40, 8'h00, {3'h0, TBL[i][16:12]}, ak);
      `CHK(ak, 3'h7)
      `CHK(route.mode, TBL[i][11:9])
      `CHK(chans, TBL[i][8:0])
      `CHK(route.power_on, pw(TBL[i][8:0]))
      u_host.rd(8'h40, 8'h00, rdat);
      `CHK(rdat[4:0], TBL[i][16:12])
    end
    $display("Test format table done");
    address_select_pin = 1'b1;
    u_host.wr(8'h40, 8'h00, 8'h01, ak);
    `CHK(ak, 3'h0)
    `CHK(route.chan_a, 3'h5)
    u_host.wr(8'h42, 8'h00, 8'h01, ak);
    `CHK(ak, 3'h7)
    `CHK(route.chan_a, 3'h2)
    address_select_pin = 1'b0;
    $display("Test address select done");
    u_host.wr(8'h40, 8'h80, 8'h80, ak);
    `CHK(ak, 3'h4)
    `CHK(adaptive_contrast_boost, 1'b0)
    for (int k = 0; k < 3; k++) begin
      u_host.wr(8'h40, 8'h0E, 8'h40, ak);
      `CHK(page_sel, 2'h2)
      u_host.wr(8'h40, 8'h80, BV[k], ak);
      `CHK(adaptive_contrast_boost, BV[k][7])
      u_host.rd(8'h40, 8'h80, rdat);
      `CHK(rdat, BV[k])
      u_host.wr(8'h40, 8'h0E, 8'h00, ak);
      `CHK(page_sel, 2'h0)
      `CHK(adaptive_contrast_boost, BV[k][7])
    end
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(adaptive_contrast_boost, 1'b0)
    $display("Test contrast boost done");
    u_host.wr(8'h40, 8'hFE, 8'h01, ak);
    `CHK(deinterlace_converter, 1'b1)
    u_host.wr(8'h40, 8'hFE, 8'h00, ak);
    `CHK(deinterlace_converter, 1'b0)
    ce = 1'b0;
    u_host.wr(8'h40, 8'h0E, 8'h40, ak);
    `CHK(ak, 3'h0)
    `CHK(page_sel, 2'h0)
    ce = 1'b1;
    $display("Test deinterlace and enable done");
    end_sim();
  end
endmodule : vis_config_tb
